/* rtl/sir_defines.vh */
// register map, field positions and reset values of the serial block
`ifndef SIR_DEFINES_VH
`define SIR_DEFINES_VH
`define SIR_OFF_MODE      8'h00
`define SIR_OFF_CTRL      8'h04
`define SIR_OFF_BAUD      8'h08
`define SIR_OFF_TXDATA    8'h0C
`define SIR_OFF_RXDATA    8'h10
`define SIR_OFF_STATUS    8'h14
`define SIR_OFF_IRCTL     8'h18
`define SIR_OFF_EXTMODE   8'h1C
`define SIR_MODE_SYNC     7
`define SIR_MODE_WLEN     6
`define SIR_MODE_PAR_ON   5
`define SIR_MODE_PAR_ODD  4
`define SIR_MODE_STOP2    3
`define SIR_MODE_SHORT    2
`define SIR_CTRL_TXEN     5
`define SIR_CTRL_RXEN     4
`define SIR_ST_TXEMPTY    7
`define SIR_ST_RXFULL     6
`define SIR_ST_OVERRUN    5
`define SIR_ST_FRAME      4
`define SIR_ST_PARITY     3
`define SIR_ST_TXEND      2
`define SIR_IR_EN         7
`define SIR_EXT_HALF      3
`define SIR_RST_REG8      8'h00
`define SIR_CKSRC_PINIO   2'b00
`define SIR_CKSRC_OUT     2'b01
`define SIR_CKSRC_EXT     2'b10
`define SIR_PW_BIT316     3'h0
`define SIR_PW_DIV4       3'h2
`define SIR_PW_DIV8       3'h3
`define SIR_PW_DIV16      3'h4
`define SIR_IRW_DIV4      6'h0C
`define SIR_IRW_DIV8      6'h18
`define SIR_IRW_DIV16     6'h30
`define SIR_IRW_316       4'h3
`endif

/* rtl/sir_uart.v */
// asynchronous serial transmitter/receiver with infrared pulse coding
`timescale 1ns/10ps
`include "sir_defines.vh"
module sir_uart (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         serial_out_pin,
  input  wire        serial_in_pin,
  input  wire        serial_clock_pin_i,
  output reg         serial_clock_pin_o,
  output wire        serial_clock_pin_oe
);
  localparam TX_IDLE = 3'd0, TX_START = 3'd1, TX_DATA = 3'd2;
  localparam TX_PAR = 3'd3, TX_STOP1 = 3'd4, TX_STOP2 = 3'd5;
  localparam RX_IDLE = 3'd0, RX_START = 3'd1, RX_DATA = 3'd2;
  localparam RX_PAR = 3'd3, RX_STOP = 3'd4;
  reg  [7:0] mode_ff, ctrl_ff, baud_ff, tdr_ff, rdr_ff, ir_ff, ext_ff;
  reg        tx_empty_ff, rx_full_ff, ovr_ff, frm_ff, per_ff, tend_ff;
  reg  [7:0] awaddr_ff, wdata_ff;
  reg        aw_got_ff, w_got_ff, wstb_ff;
  reg  [7:0] div_ff;
  reg  [2:0] sck_sync_ff, rx_sync_ff;
  reg  [3:0] tph_ff, rph_ff, irh_ff;
  reg  [2:0] tx_st_ff, rx_st_ff, tidx_ff, ridx_ff;
  reg  [7:0] tsr_ff, rsh_ff;
  reg        tpar_ff, rpar_ff, rperr_ff, rline_prev_ff;
  reg  [5:0] irc_ff;
  // bus side
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire       wr_go  = (aw_got_ff | aw_take) & (w_got_ff | w_take);
  wire [7:0] wa     = aw_take ? s_axi_awaddr : awaddr_ff;
  wire [7:0] wd     = w_take ? s_axi_wdata[7:0] : wdata_ff;
  wire       wlane  = w_take ? s_axi_wstrb[0] : wstb_ff;
  wire       wr_en  = wr_go & wlane;
  wire       wr_tdr = wr_en & (wa == `SIR_OFF_TXDATA);
  wire       wr_st  = wr_en & (wa == `SIR_OFF_STATUS);
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire       rd_rdr = ar_take & (s_axi_araddr == `SIR_OFF_RXDATA);
  wire       wr_map = (wa[7:5] == 3'b000) & (wa[1:0] == 2'b00);
  // configuration decode
  wire       ir_en  = ir_ff[`SIR_IR_EN];
  wire [2:0] pw_sel = ir_ff[6:4];
  wire       half   = ext_ff[`SIR_EXT_HALF] &
                      ~mode_ff[`SIR_MODE_SYNC];
  wire [3:0] ph_last = half ? 4'h7 : 4'hF;
  wire [3:0] ph_samp = half ? 4'h3 : 4'h7;
  wire       short  = mode_ff[`SIR_MODE_SHORT];
  wire       par_on = mode_ff[`SIR_MODE_PAR_ON];
  wire       wlen7  = mode_ff[`SIR_MODE_WLEN];
  // short word: parity bit present only with the 7-bit selection
  wire [2:0] last_idx = (short & par_on) ? 3'd4 :
                        (wlen7 ? 3'd6 : 3'd7);
  wire       has_par = short ? wlen7 : par_on;
  wire       odd     = mode_ff[`SIR_MODE_PAR_ODD];
  wire       stop2   = mode_ff[`SIR_MODE_STOP2];
  wire [1:0] cksrc   = ctrl_ff[1:0];
  wire       txen    = ctrl_ff[`SIR_CTRL_TXEN];
  wire       rxen    = ctrl_ff[`SIR_CTRL_RXEN];
  // oversample tick: divider or external pin edge
  wire ext_clk = (cksrc == `SIR_CKSRC_EXT);
  wire os_tick = ext_clk ? (sck_sync_ff[1] & ~sck_sync_ff[2]) :
                           (div_ff >= baud_ff);
  assign serial_clock_pin_oe = ~mode_ff[`SIR_MODE_SYNC] &
                               (cksrc == `SIR_CKSRC_OUT);
  // free running transmit bit clock
  wire tbit_end = os_tick & (tph_ff == ph_last);
  wire tx_avail = txen & ~tx_empty_ff;
  reg        tx_load, tx_fin;
  reg  [2:0] nxt_tx_st;
  always @* begin
    tx_load   = 1'b0;
    tx_fin    = 1'b0;
    nxt_tx_st = tx_st_ff;
    if (tbit_end) begin
      case (tx_st_ff)
        TX_IDLE:  if (tx_avail) begin
          tx_load   = 1'b1;
          nxt_tx_st = TX_START;
        end
        TX_START: nxt_tx_st = TX_DATA;
        TX_DATA:  if (tidx_ff == last_idx)
          nxt_tx_st = has_par ? TX_PAR : TX_STOP1;
        TX_PAR:   nxt_tx_st = TX_STOP1;
        TX_STOP1: if (stop2) nxt_tx_st = TX_STOP2;
          else tx_fin = 1'b1;
        TX_STOP2: tx_fin = 1'b1;
        default:  nxt_tx_st = TX_IDLE;
      endcase
      // back to back frames when the holding register is full
      if (tx_fin) begin
        tx_load   = tx_avail;
        nxt_tx_st = tx_avail ? TX_START : TX_IDLE;
      end
    end
  end
  reg txbit;
  always @* begin
    case (tx_st_ff)
      TX_START: txbit = 1'b0;
      TX_DATA:  txbit = tsr_ff[0];
      TX_PAR:   txbit = tpar_ff ^ odd;
      default:  txbit = 1'b1;
    endcase
  end
  reg ir_pulse;
  always @* begin
    case (pw_sel)
      `SIR_PW_DIV4:  ir_pulse = irc_ff < `SIR_IRW_DIV4;
      `SIR_PW_DIV8:  ir_pulse = irc_ff < `SIR_IRW_DIV8;
      `SIR_PW_DIV16: ir_pulse = irc_ff < `SIR_IRW_DIV16;
      default:       ir_pulse = tph_ff < `SIR_IRW_316;
    endcase
  end
  // receive path; pulse stretched into one low bit when coded
  wire rline = ir_en ? (irh_ff == 4'h0) : rx_sync_ff[2];
  wire r_samp = os_tick & (rph_ff == ph_samp);
  wire r_done = r_samp & (rx_st_ff == RX_STOP);
  reg [7:0] r_align;
  always @* begin
    case (last_idx)
      3'd4:    r_align = {3'b000, rsh_ff[7:3]};
      3'd6:    r_align = {1'b0, rsh_ff[7:1]};
      default: r_align = rsh_ff;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= `SIR_RST_REG8;
      ctrl_ff <= `SIR_RST_REG8;
      baud_ff <= `SIR_RST_REG8;
      tdr_ff <= `SIR_RST_REG8;
      rdr_ff <= `SIR_RST_REG8;
      ir_ff <= `SIR_RST_REG8;
      ext_ff <= `SIR_RST_REG8;
      tx_empty_ff <= 1'b1;
      rx_full_ff <= 1'b0;
      ovr_ff <= 1'b0;
      frm_ff <= 1'b0;
      per_ff <= 1'b0;
      tend_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      div_ff <= 8'h00;
      sck_sync_ff <= 3'b000;
      rx_sync_ff <= 3'b111;
      tph_ff <= 4'h0;
      rph_ff <= 4'h0;
      irh_ff <= 4'h0;
      irc_ff <= 6'h00;
      tx_st_ff <= TX_IDLE;
      rx_st_ff <= RX_IDLE;
      rline_prev_ff <= 1'b1;
      serial_out_pin <= 1'b1;
      serial_clock_pin_o <= 1'b0;
    end else begin
      // write channel pairing, either order
      if (aw_take & ~wr_go) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take & ~wr_go) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstb_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_en) begin
        case (wa)
          `SIR_OFF_MODE:    mode_ff <= {wd[7:2], 2'b00};
          `SIR_OFF_CTRL:    ctrl_ff <= {2'b00, wd[5:4], 2'b00, wd[1:0]};
          `SIR_OFF_BAUD:    baud_ff <= wd;
          `SIR_OFF_TXDATA:  tdr_ff <= wd;
          `SIR_OFF_IRCTL:   ir_ff <= {wd[7:4], 4'h0};
          `SIR_OFF_EXTMODE: ext_ff <= {4'h0, wd[3], 3'b000};
          default: ;
        endcase
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `SIR_OFF_MODE:    s_axi_rdata <= {24'h00_0000, mode_ff};
          `SIR_OFF_CTRL:    s_axi_rdata <= {24'h00_0000, ctrl_ff};
          `SIR_OFF_BAUD:    s_axi_rdata <= {24'h00_0000, baud_ff};
          `SIR_OFF_TXDATA:  s_axi_rdata <= {24'h00_0000, tdr_ff};
          `SIR_OFF_RXDATA:  s_axi_rdata <= {24'h00_0000, rdr_ff};
          `SIR_OFF_STATUS:  s_axi_rdata <= {24'h00_0000, tx_empty_ff,
            rx_full_ff, ovr_ff, frm_ff, per_ff, tend_ff, 2'b00};
          `SIR_OFF_IRCTL:   s_axi_rdata <= {24'h00_0000, ir_ff};
          `SIR_OFF_EXTMODE: s_axi_rdata <= {24'h00_0000, ext_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // clocking; synchroniser first stages feed only the next stage
      sck_sync_ff <= {sck_sync_ff[1:0], serial_clock_pin_i};
      rx_sync_ff <= {rx_sync_ff[1:0], serial_in_pin};
      div_ff <= (div_ff >= baud_ff) ? 8'h00 : div_ff + 8'h01;
      if (os_tick)
        tph_ff <= (tph_ff == ph_last) ? 4'h0 : tph_ff + 4'h1;
      serial_clock_pin_o <= half ? tph_ff[2] : tph_ff[3];
      // transmitter
      tx_st_ff <= nxt_tx_st;
      if (tbit_end) begin
        irc_ff <= 6'h00;
        if (tx_st_ff == TX_DATA) begin
          tsr_ff <= {1'b0, tsr_ff[7:1]};
          tpar_ff <= tpar_ff ^ tsr_ff[0];
          tidx_ff <= tidx_ff + 3'd1;
        end
      end else if (irc_ff != 6'h3F)
        irc_ff <= irc_ff + 6'h01;
      if (tx_load) begin
        tsr_ff <= wr_tdr ? wd : tdr_ff;
        tpar_ff <= 1'b0;
        tidx_ff <= 3'd0;
      end
      // hardware set beats software write
      if (tx_load | ~txen)
        tx_empty_ff <= 1'b1;
      else if (wr_tdr)
        tx_empty_ff <= 1'b0;
      if (tx_fin & ~tx_avail)
        tend_ff <= 1'b1;
      else if (tx_load)
        tend_ff <= 1'b0;
      serial_out_pin <= ir_en ? (~txbit & ir_pulse) : txbit;
      // receiver
      rline_prev_ff <= rline;
      if (ir_en & rx_sync_ff[1] & ~rx_sync_ff[2])
        irh_ff <= ph_last;
      else if (os_tick & (irh_ff != 4'h0))
        irh_ff <= irh_ff - 4'h1;
      if (os_tick)
        rph_ff <= (rph_ff == ph_last) ? 4'h0 : rph_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE: if (rxen & rline_prev_ff & ~rline) begin
          rx_st_ff <= RX_START;
          rph_ff <= 4'h0;
        end
        RX_START: if (r_samp) begin
          rx_st_ff <= rline ? RX_IDLE : RX_DATA;
          ridx_ff <= 3'd0;
          rpar_ff <= 1'b0;
          rperr_ff <= 1'b0;
        end
        RX_DATA: if (r_samp) begin
          rsh_ff <= {rline, rsh_ff[7:1]};
          rpar_ff <= rpar_ff ^ rline;
          ridx_ff <= ridx_ff + 3'd1;
          if (ridx_ff == last_idx)
            rx_st_ff <= has_par ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (r_samp) begin
          rperr_ff <= (rpar_ff ^ rline) != odd;
          rx_st_ff <= RX_STOP;
        end
        RX_STOP: if (r_samp)
          rx_st_ff <= RX_IDLE;
        default: rx_st_ff <= RX_IDLE;
      endcase
      if (r_done & ~rx_full_ff)
        rdr_ff <= r_align;
      if (r_done & ~rx_full_ff)
        rx_full_ff <= 1'b1;
      else if (rd_rdr)
        rx_full_ff <= 1'b0;
      if (r_done & rx_full_ff)
        ovr_ff <= 1'b1;
      else if (wr_st & ~wd[`SIR_ST_OVERRUN])
        ovr_ff <= 1'b0;
      if (r_done & ~rline)
        frm_ff <= 1'b1;
      else if (wr_st & ~wd[`SIR_ST_FRAME])
        frm_ff <= 1'b0;
      if (r_done & rperr_ff & ~rx_full_ff)
        per_ff <= 1'b1;
      else if (wr_st & ~wd[`SIR_ST_PARITY])
        per_ff <= 1'b0;
    end
  end
endmodule // sir_uart

/* testbench/sir_uart_asserts.sv */
// bus and clock pin assertions for the serial block
`timescale 1ns/10ps
`include "sir_defines.vh"
module sir_uart_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        serial_out_pin,
  input wire        serial_clock_pin_o,
  input wire        serial_clock_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg  [1:0] ck_ff;
  reg        sy_ff;
  reg  [7:0] ra_ff;
  // shadows only see writes whose address and data meet in one cycle
  wire       wtk = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready && s_axi_wstrb[0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      ck_ff <= 2'b00;
      sy_ff <= 1'b0;
      ra_ff <= 8'h00;
    end else begin
      if (wtk && s_axi_awaddr == `SIR_OFF_CTRL)
        ck_ff <= s_axi_wdata[1:0];
      if (wtk && s_axi_awaddr == `SIR_OFF_MODE)
        sy_ff <= s_axi_wdata[`SIR_MODE_SYNC];
      if (s_axi_arvalid && s_axi_arready)
        ra_ff <= s_axi_araddr;
    end
  end
  a_write_answer: assert property (wtk |=> s_axi_bvalid)
    else $error("no write response after write");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read data after read");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_unmapped_slverr: assert property (s_axi_rvalid
    && ra_ff > `SIR_OFF_EXTMODE |-> s_axi_rresp == 2'b10
    && s_axi_rdata == 32'h0000_0000) else $error("unmapped read answered");
  a_reserved_zero: assert property (
    s_axi_rvalid && (ra_ff == `SIR_OFF_IRCTL || ra_ff == `SIR_OFF_EXTMODE)
    |-> (ra_ff == `SIR_OFF_EXTMODE
    ? {s_axi_rdata[7:4], s_axi_rdata[2:0]} == 7'h00
    : s_axi_rdata[3:0] == 4'h0)) else $error("reserved bits not zero");
  a_clock_midbit: assert property (
    serial_clock_pin_oe && $rose(serial_clock_pin_o)
    |-> $stable(serial_out_pin)[*3]) else $error("clock edge not mid bit");
  a_clock_pin_enable: assert property (
    serial_clock_pin_oe == (ck_ff == `SIR_CKSRC_OUT && !sy_ff))
    else $error("clock pin drive wrong");
  c_write: cover property (wtk);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_clock_out: cover property (serial_clock_pin_oe
    && $rose(serial_clock_pin_o));
endmodule // sir_uart_asserts
bind sir_uart sir_uart_asserts chk (.*);

/* testbench/sir_line_model.sv */
// remote serial or infrared transceiver facing the line pins
`timescale 1ns/10ps
module sir_line_model (
  input  wire  aclk,
  input  wire  line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic idle(input logic ir);
    @(posedge aclk);
    line_out <= !ir;
  endtask
  task automatic send(input logic [15:0] f, input int n, bl, ir);
    for (int i = 0; i < n; i++)
      for (int j = 0; j < bl; j++)
        @(posedge aclk) line_out <= ir ? (!f[i] && j < bl * 3 / 16)
          : f[i];
    @(posedge aclk);
    line_out <= !ir[0];
  endtask
  // infrared bit is zero when any pulse falls inside its window
  task automatic recv(input int n, bl, ir, output logic [15:0] b);
    int k;
    logic hi, mid;
    b = 'x;
    k = 0;
    while (line_in !== ir[0] && k < 30000) @(posedge aclk) k++;
    if (k == 30000) return;
    for (int i = 0; i < n; i++) begin
      hi = 1'b0;
      for (int j = 0; j < bl; j++) begin
        if (j == bl / 2) mid = line_in;
        hi |= line_in;
        @(posedge aclk);
      end
      b[i] = ir ? !hi : mid;
    end
  endtask
endmodule // sir_line_model

/* testbench/sir_uart_test.sv */
// self-checking bench: bus, frames, infrared and clock pin
`timescale 1ns/10ps
`include "sir_defines.vh"
module sir_uart_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, serial_out_pin;
  logic serial_in_pin, serial_clock_pin_i, serial_clock_pin_o;
  logic serial_clock_pin_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] f1, f2, g1, g2;
  int          num_errors, n_tests, w, k;
  int          pw[4] = '{0, 2, 3, 4};
  int          pwid[4] = '{18, 12, 24, 48};
  logic [7:0]  cfg[10] = '{8'h00, 8'h08, 8'h20, 8'h38, 8'h40, 8'h68,
                           8'h70, 8'h24, 8'h64, 8'h6c};
  sir_uart uut (.*);
  sir_line_model rmt (.aclk(aclk), .line_in(serial_out_pin),
                      .line_out(serial_in_pin));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // free running: the far side must clock even while idle
  always begin
    repeat (3) @(posedge aclk);
    serial_clock_pin_i <= ~serial_clock_pin_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    logic ta, tw, tb;
    k = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!tb && k < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      k++;
    end
    if (!tb) num_errors++;
    if (!tb) tally_and_finish();
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    logic ta, tk;
    k = 0;
    tk = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!tk && k < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid && s_axi_rready;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) s_axi_rready <= 1'b0;
      k++;
    end
    if (!tk) num_errors++;
    if (!tk) tally_and_finish();
  endtask
  function automatic int frame(input logic [7:0] m, d,
                               output logic [15:0] f);
    int n;
    logic p;
    n = m[2] ? 5 : (m[6] ? 7 : 8);
    p = m[2] ? m[6] : m[5];
    f = 16'hffff;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i + 1] = d[i];
    if (p) f[n + 1] = ^(d & (8'hff >> (8 - n))) ^ m[4];
    return 2 + n + p + m[3];
  endfunction
  // e flips parity, or first of two stops, in the frame sent in
  task automatic xfer(input logic [7:0] m, c, h, ir, b, input int bl, e);
    logic [15:0] f, g, got;
    logic [7:0]  d;
    int          len, n, p;
    d = 8'($urandom);
    len = frame(m, d, f);
    n = m[2] ? 5 : (m[6] ? 7 : 8);
    p = m[2] ? m[6] : m[5];
    if (!p && !m[3]) e = 0;
    g = f;
    if (e != 0) g[n + 1] = ~g[n + 1];
    wr(`SIR_OFF_MODE, m);
    wr(`SIR_OFF_EXTMODE, h);
    wr(`SIR_OFF_IRCTL, ir);
    wr(`SIR_OFF_BAUD, b);
    wr(`SIR_OFF_CTRL, c);
    rmt.idle(ir[7]);
    fork
      begin
        wr(`SIR_OFF_TXDATA, d);
        rmt.recv(len, bl, ir[7], got);
      end
      rmt.send(g, len, bl, ir[7]);
    join
    chk("tx frame", f & ~(16'hffff << len), got & ~(16'hffff << len));
    repeat (bl) @(posedge aclk);
    rd(`SIR_OFF_STATUS);
    chk("status", {3'b110, e != 0 && p == 0, e != 0 && p != 0, 3'b100}, rdat);
    rd(`SIR_OFF_RXDATA);
    chk("rx data", d & (8'hff >> (8 - n)), rdat);
    wr(`SIR_OFF_STATUS, 32'h0000_0000);
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, serial_clock_pin_i} = 3'b000;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    num_errors = 0;
    n_tests = 0;
    void'($urandom(32'h97c9_3861));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i));
      chk("reset value", i == 5 ? 32'h0000_0084 : 32'h0000_0000, rdat);
    end
    wr(`SIR_OFF_IRCTL, 32'h0000_00ff);
    rd(`SIR_OFF_IRCTL);
    chk("infrared_control", 32'h0000_00f0, rdat);
    wr(`SIR_OFF_EXTMODE, 32'h0000_00ff);
    rd(`SIR_OFF_EXTMODE);
    chk("extended_mode", 32'h0000_0008, rdat);
    wr(8'h20, 32'h0000_0001);
    chk("unmapped write", 2'b10, rsp);
    rd(8'h20);
    chk("unmapped read", 2'b10, rsp);
    chk("unmapped read data", 32'h0000_0000, rdat);
    for (int i = 0; i < 20; i++)
      xfer(cfg[i / 2], 8'h30, 8'(8 * (i % 2)), 8'h00, 8'h01, 32 >> (i % 2),
           i % 3);
    xfer(8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 96, 0);
    xfer(8'h00, 8'h31, 8'h00, 8'h00, 8'h00, 16, 0);
    @(negedge aclk);
    chk("clock pin enable", 1, serial_clock_pin_oe);
    wr(`SIR_OFF_CTRL, 8'h33);
    @(negedge aclk);
    chk("clock pin enable", 0, serial_clock_pin_oe);
    wr(`SIR_OFF_CTRL, 8'h30);
    k = frame(8'h00, 8'h5a, f1);
    k = frame(8'h00, 8'hc3, f2);
    rdat = 32'h0000_0000;
    fork
      begin
        wr(`SIR_OFF_TXDATA, 8'h5a);
        for (k = 0; k < 50 && !rdat[7]; k++) rd(`SIR_OFF_STATUS);
        wr(`SIR_OFF_TXDATA, 8'hc3);
      end
      begin
        rmt.recv(10, 16, 0, g1);
        rmt.recv(10, 16, 0, g2);
      end
    join
    chk("first frame", f1[9:0], g1[9:0]);
    chk("second frame", f2[9:0], g2[9:0]);
    // infrared last: leaving it makes the receiver decode junk
    for (int i = 0; i < 4; i++) begin
      fork
        xfer(8'h00, 8'h30, 8'h00, 8'(8'h80 | pw[i] << 4), 8'h05, 96, 0);
        begin
          k = 0;
          while (serial_out_pin && k < 5000) @(posedge aclk) k++;
          while (!serial_out_pin && k < 9000) @(posedge aclk) k++;
          w = 0;
          while (serial_out_pin && w < 200) @(posedge aclk) w++;
        end
      join
      chk("pulse width", pwid[i], w);
    end
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    chk("run length", 0, 1);
    tally_and_finish();
  end
endmodule // sir_uart_test
